/* File: hw/usft_pkg.sv */
/*
  usft_pkg: register map, field layout, reset values, frame format carrier
  and frame helpers for the serial frame transmitter.
  Assumes one 50 MHz APB clock and an APB master with 32-bit data.
*/
// Functional notes
// RULE1: sync mode: transfer clock pin in slave, out master
// RULE2: sample on edge opposite to data change
// RULE3: polarity clear: change rising, sample falling
// RULE4: all thirty frame formats supported
// RULE5: start bit, data LSB first, parity, stop
// RULE6: next frame follows at once or line idles high
// RULE7: receiver and transmitter share one frame format
// RULE8: size, parity and stop fields select format
// RULE9: receiver flags error only on first stop
// RULE10: parity is xor of data, inverted if odd
// RULE11: transmit enable takes over serial output pin
// RULE12: sync transmit uses transfer clock pin as clock
// RULE13: data register write loads buffer, starts sending
// RULE14: buffer moves to shifter when idle or after stop
// RULE15: shifter sends frame at baud or external rate
// RULE16: unused upper data bits are ignored
// RULE17: host writes ninth bit before low byte
// RULE18: empty flag shows buffer free; host waits
// RULE19: host changes format only when link quiet
// RULE20: host clears complete flag before each write
// RULE21: ninth bit marks address frames in multiprocessor
// RULE22: complete flag set when all sent; one clears
// RULE23: data register write clears empty flag
// RULE24: parity active when parity upper bit set
// RULE25: bit clock is baud output over 16, 8, 2
// RULE26: parity codes: 00 off, 10 even, 11 odd
// RULE27: enabled and idle: output driven high
package usft_pkg;
  localparam int ADDR_W = 8;
  localparam int BAUD_W = 12;
  localparam int FRAME_MAX = 13;
  // register byte offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  // ctrl_status_b fields
  localparam int CB_TX_ENABLE = 0;
  localparam int CB_TX9 = 1;
  // ctrl_status_c fields
  localparam int CC_SYNC = 0;
  localparam int CC_MASTER = 1;
  localparam int CC_PAR = 2;
  localparam int CC_STOP = 4;
  localparam int CC_SIZE = 5;
  localparam int CC_POL = 8;
  // status fields
  localparam int ST_TBE = 0;
  localparam int ST_TXC = 1;
  localparam int ST_U2X = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_RX_DONE = 4;
  // prescaler end counts for 16 and 8 baud ticks per bit
  localparam logic [3:0] PRE_NORMAL_MAX = 4'hF;
  localparam logic [3:0] PRE_DOUBLE_MAX = 4'h7;
  localparam logic [BAUD_W-1:0] BAUD_RST = 12'h000;
  localparam logic SYNC_RST = 1'b1;
  localparam int SYNC_XCK = 0;
  localparam int SYNC_RXD = 1;

  // frame format shared by transmitter and receiver
  typedef struct packed {
    logic pol;
    logic [2:0] size;
    logic stop2;
    logic [1:0] parity;
    logic sync;
  } usft_fmt_t;

  localparam usft_fmt_t FMT_RST = '{pol: 1'b0, size: 3'h3, stop2: 1'b0, parity: 2'h0, sync: 1'b0};

  // character size code to number of data bits; reserved codes give eight
  function automatic logic [3:0] usft_data_bits(input logic [2:0] size);
    case (size)
      3'h0: usft_data_bits = 4'h5;
      3'h1: usft_data_bits = 4'h6;
      3'h2: usft_data_bits = 4'h7;
      3'h7: usft_data_bits = 4'h9;
      default: usft_data_bits = 4'h8;
    endcase
  endfunction
endpackage // usft_pkg

/* File: hw/usft_rx_sync.sv */
/*
  usft_rx_sync: synchronous-mode receiver frame walker; samples one bit per
  sample pulse, keeps the data bits, checks only the first stop bit.
  Assumes din is already synchronised and smp is a one-cycle pulse.
*/
module usft_rx_sync (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic en, // synchronous mode active
  input wire logic smp, // sample edge pulse
  input wire logic din, // synchronised serial input
  input usft_pkg::usft_fmt_t fmt, // shared frame format
  output logic [8:0] rx_word, // received character
  output logic rx_stop_err, // first stop bit was zero
  output logic rx_valid // one-cycle frame done pulse
);
  import usft_pkg::*;

  logic busy;
  logic [3:0] pos;
  logic [8:0] sh;
  logic [3:0] n;
  logic [3:0] last;

  // data bits, optional parity, then the first stop bit only
  assign n = usft_data_bits(fmt.size);
  assign last = 4'(n + {3'h0, fmt.parity[1]});

  // frame walk; a second stop bit simply idles high and is never looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      pos <= 4'h0;
      sh <= 9'h000;
      rx_word <= 9'h000;
      rx_stop_err <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!en) begin
        busy <= 1'b0;
      end else if (smp) begin
        if (!busy) begin
          busy <= ~din;
          pos <= 4'h0;
        end else if (pos < n) begin
          sh <= {din, sh[8:1]};
          pos <= pos + 4'h1;
        end else if (pos < last) begin
          pos <= pos + 4'h1;
        end else begin
          rx_word <= sh >> (4'h9 - n);
          rx_stop_err <= ~din; // [RULE9]
          rx_valid <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  stop_check_a: assert property ((en && smp && busy && pos >= last) |=> rx_valid && (rx_stop_err == !$past(din))) // [RULE9]
    else $error("frame error does not follow first stop bit");
endmodule // usft_rx_sync

/* File: hw/usft_top.sv */
/*
  usft_top: serial frame transmitter with APB register file, baud generator,
  synchronous transfer clock handling and a synchronous-mode receiver check.
  Assumes pclk at 50 MHz, APB master, pins synchronised here.
*/
// The APB interface to the registers and the address map were decided locally.
module usft_top (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [usft_pkg::ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // always ready
  output logic pslverr, // unmapped access
  output logic serial_out_pin, // serial data out
  output logic serial_out_oe, // transmitter owns the pin
  input wire logic serial_in_pin, // serial data in
  input wire logic xfer_clock_in, // transfer clock from pin
  output logic xfer_clock_out, // transfer clock to pin
  output logic xfer_clock_oe // drive transfer clock pin
);
  import usft_pkg::*;

  logic tx_en, tx_ninth, u2x, master;
  usft_fmt_t fmt;
  logic [BAUD_W-1:0] baud_divisor;
  logic buf_valid;
  logic [8:0] buf_data;
  logic txc, rx_done, frame_err;
  logic [FRAME_MAX-1:0] shreg;
  logic [FRAME_MAX-1:0] frame;
  logic [3:0] bits_left;
  logic busy;
  logic setup, access, addr_ok, wr, rd_data;
  logic [31:0] next_prdata;
  logic [BAUD_W-1:0] baud_cnt;
  logic baud_tick;
  logic [3:0] pre_cnt;
  logic [3:0] pre_max;
  logic async_tick;
  logic xck_q;
  logic m_chg, m_smp, s_chg, s_smp;
  logic chg_edge, smp_edge;
  logic load, frame_end;
  logic [3:0] n;
  logic [3:0] frame_len;
  logic [8:0] dmask;
  logic par_en, par_bit;
  logic [1:0] pin_raw, pin_lvl, pin_rise, pin_fall;
  logic [8:0] rx_word;
  logic rx_stop_err, rx_valid;

  // apb decode; zero wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  always_comb begin
    case (paddr)
      ADDR_DATA, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_STATUS, ADDR_BAUD: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign wr = access & pwrite & addr_ok;
  assign rd_data = setup & ~pwrite & (paddr == ADDR_DATA);
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;

  // ctrl_status_b: transmit enable and ninth bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en <= 1'b0;
      tx_ninth <= 1'b0;
    end else if (wr && paddr == ADDR_CTRL_B) begin
      tx_en <= pwdata[CB_TX_ENABLE];
      tx_ninth <= pwdata[CB_TX9];
    end
  end

  // ctrl_status_c: one frame format for both directions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt <= FMT_RST;
      master <= 1'b0;
    end else if (wr && paddr == ADDR_CTRL_C) begin
      fmt.sync <= pwdata[CC_SYNC]; // [RULE1]
      master <= pwdata[CC_MASTER];
      fmt.parity <= pwdata[CC_PAR +: 2]; // [RULE8]
      fmt.stop2 <= pwdata[CC_STOP];
      fmt.size <= pwdata[CC_SIZE +: 3];
      fmt.pol <= pwdata[CC_POL]; // [RULE3]
    end
  end

  // double speed bit and baud divisor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u2x <= 1'b0;
      baud_divisor <= BAUD_RST;
    end else if (wr && paddr == ADDR_STATUS) begin
      u2x <= pwdata[ST_U2X];
    end else if (wr && paddr == ADDR_BAUD) begin
      baud_divisor <= pwdata[BAUD_W-1:0];
    end
  end

  // transmit buffer; a write in the load cycle keeps the buffer full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_valid <= 1'b0;
      buf_data <= 9'h000;
    end else if (wr && paddr == ADDR_DATA) begin
      buf_valid <= 1'b1; // [RULE13] [RULE23]
      buf_data <= {tx_ninth, pwdata[7:0]}; // [RULE17] [RULE21]
    end else if (load) begin
      buf_valid <= 1'b0; // [RULE18]
    end
  end

  // transmit complete: set beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc <= 1'b0;
    end else if (frame_end && !buf_valid) begin
      txc <= 1'b1; // [RULE22]
    end else if (wr && paddr == ADDR_STATUS && pwdata[ST_TXC]) begin
      txc <= 1'b0;
    end
  end

  // receive flags; a new frame beats the clearing data read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done <= 1'b0;
      frame_err <= 1'b0;
    end else if (rx_valid) begin
      rx_done <= 1'b1;
      frame_err <= rx_stop_err; // [RULE9]
    end else if (rd_data) begin
      rx_done <= 1'b0;
    end
  end

  // read mux, captured in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_DATA: next_prdata[8:0] = rx_word;
      ADDR_CTRL_B: begin
        next_prdata[CB_TX_ENABLE] = tx_en;
        next_prdata[CB_TX9] = tx_ninth;
      end
      ADDR_CTRL_C: begin
        next_prdata[CC_SYNC] = fmt.sync;
        next_prdata[CC_MASTER] = master;
        next_prdata[CC_PAR +: 2] = fmt.parity;
        next_prdata[CC_STOP] = fmt.stop2;
        next_prdata[CC_SIZE +: 3] = fmt.size;
        next_prdata[CC_POL] = fmt.pol;
      end
      ADDR_STATUS: begin
        next_prdata[ST_TBE] = ~buf_valid; // [RULE18]
        next_prdata[ST_TXC] = txc;
        next_prdata[ST_U2X] = u2x;
        next_prdata[ST_FRAME_ERR] = frame_err;
        next_prdata[ST_RX_DONE] = rx_done;
      end
      ADDR_BAUD: next_prdata[BAUD_W-1:0] = baud_divisor;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // baud down-counter, reloaded at zero or when the divisor is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= BAUD_RST;
    end else if (wr && paddr == ADDR_BAUD) begin
      baud_cnt <= pwdata[BAUD_W-1:0];
    end else if (baud_cnt == '0) begin
      baud_cnt <= baud_divisor;
    end else begin
      baud_cnt <= baud_cnt - 1'b1;
    end
  end
  assign baud_tick = (baud_cnt == '0);

  // async bit clock: baud output over 16, or 8 at double speed
  assign pre_max = u2x ? PRE_DOUBLE_MAX : PRE_NORMAL_MAX; // [RULE25]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 4'h0;
    end else if (baud_tick) begin
      pre_cnt <= (pre_cnt >= pre_max) ? 4'h0 : pre_cnt + 4'h1;
    end
  end
  assign async_tick = baud_tick & (pre_cnt >= pre_max);

  // master transfer clock: one toggle per baud tick, two ticks per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xck_q <= 1'b0;
    end else if (!(fmt.sync && master)) begin
      xck_q <= fmt.pol;
    end else if (baud_tick) begin
      xck_q <= ~xck_q; // [RULE25]
    end
  end
  assign xfer_clock_out = xck_q;
  assign xfer_clock_oe = fmt.sync & master; // [RULE1] [RULE12]

  // pin synchronisers; a change counts once stages two and three agree
  assign pin_raw = {serial_in_pin, xfer_clock_in};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      logic s1, s2, s3, lvl;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= SYNC_RST;
          s2 <= SYNC_RST;
          s3 <= SYNC_RST;
          lvl <= SYNC_RST;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
      assign pin_lvl[g] = lvl;
      assign pin_rise[g] = (s2 == s3) & s3 & ~lvl;
      assign pin_fall[g] = (s2 == s3) & ~s3 & lvl;
    end
  endgenerate

  // data change and sample edges: opposite edges, same for both roles
  assign m_chg = baud_tick & (xck_q == fmt.pol); // [RULE2] [RULE3]
  assign m_smp = baud_tick & (xck_q != fmt.pol);
  assign s_chg = fmt.pol ? pin_fall[SYNC_XCK] : pin_rise[SYNC_XCK]; // [RULE3]
  assign s_smp = fmt.pol ? pin_rise[SYNC_XCK] : pin_fall[SYNC_XCK]; // [RULE2]
  always_comb begin
    if (!fmt.sync) begin
      chg_edge = async_tick; // [RULE15]
      smp_edge = 1'b0;
    end else if (master) begin
      chg_edge = m_chg;
      smp_edge = m_smp;
    end else begin
      chg_edge = s_chg; // [RULE12] [RULE15]
      smp_edge = s_smp;
    end
  end

  // frame assembly: start, data LSB first, parity, stop bits
  assign n = usft_data_bits(fmt.size); // [RULE4] [RULE8]
  assign dmask = buf_data & (9'h1FF >> (4'h9 - n)); // [RULE16]
  assign par_en = fmt.parity[1]; // [RULE24] [RULE26]
  assign par_bit = (^dmask) ^ fmt.parity[0]; // [RULE10]
  assign frame_len = 4'(4'h2 + n + {3'h0, par_en} + {3'h0, fmt.stop2});
  always_comb begin
    frame = '1;
    frame[0] = 1'b0; // [RULE5]
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        frame[1 + i] = dmask[i];
      end
    end
    if (par_en) begin
      frame[1 + n] = par_bit; // [RULE5] [RULE10]
    end
  end

  // load when idle or right after the last stop bit of the frame
  assign frame_end = chg_edge & busy & (bits_left == 4'h1);
  assign load = chg_edge & buf_valid & (tx_en | busy) & ~(busy & (bits_left > 4'h1)); // [RULE14]

  // shift register; idle fills with ones so the line rests high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= '1;
      bits_left <= 4'h0;
      busy <= 1'b0;
    end else if (load) begin
      shreg <= frame; // [RULE6] [RULE14]
      bits_left <= frame_len; // [RULE4]
      busy <= 1'b1;
    end else if (chg_edge && busy && bits_left > 4'h1) begin
      shreg <= {1'b1, shreg[FRAME_MAX-1:1]}; // [RULE15]
      bits_left <= bits_left - 4'h1;
    end else if (frame_end) begin
      shreg <= '1; // [RULE6] [RULE27]
      bits_left <= 4'h0;
      busy <= 1'b0;
    end
  end

  // pin takeover lasts until a pending frame has gone out
  assign serial_out_pin = shreg[0]; // [RULE27]
  assign serial_out_oe = tx_en | busy; // [RULE11]

  // receiver shares the single format and the sample edge
  usft_rx_sync u_rx (
    .clk(pclk),
    .rst_n(presetn),
    .en(fmt.sync),
    .smp(smp_edge),
    .din(pin_lvl[SYNC_RXD]),
    .fmt(fmt), // [RULE7]
    .rx_word(rx_word),
    .rx_stop_err(rx_stop_err),
    .rx_valid(rx_valid)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_data_write;
    wr && paddr == ADDR_DATA;
  endsequence
  sequence s_start_out;
    busy && !serial_out_pin;
  endsequence

  buf_fill_a: assert property (s_data_write |=> buf_valid) // [RULE13]
    else $error("data write did not fill the buffer");
  tbe_hold_a: assert property ((!buf_valid && !(wr && paddr == ADDR_DATA)) |=> !buf_valid) // [RULE18]
    else $error("buffer filled without a data write");
  start_bit_a: assert property (load |=> s_start_out ##0 (bits_left == $past(frame_len))) // [RULE5]
    else $error("frame did not open with a start bit");
  back_to_back_a: assert property ((frame_end && buf_valid) |-> load) // [RULE14]
    else $error("pending data not loaded after last stop bit");
  txc_set_a: assert property ((frame_end && !buf_valid) |=> txc && !busy && serial_out_pin) // [RULE22]
    else $error("transmit complete not set after last frame");
  idle_high_a: assert property ((tx_en && !busy) |-> serial_out_pin && serial_out_oe) // [RULE27]
    else $error("enabled idle line not driven high");
  oe_hold_a: assert property ((busy && !tx_en) |-> serial_out_oe) // [RULE11]
    else $error("pin released during a frame");
  parity_a: assert property ((load && par_en) |=> shreg[1 + $past(n)] == ((^$past(dmask)) ^ $past(fmt.parity[0]))) // [RULE10]
    else $error("parity bit does not match data");
  xck_dir_a: assert property ((fmt.sync && master && baud_tick) |=> xfer_clock_out != $past(xfer_clock_out)) // [RULE1]
    else $error("master transfer clock not toggling");
  sync_change_a: assert property ((fmt.sync && busy && $changed(serial_out_pin)) |-> $past(chg_edge)) // [RULE3]
    else $error("sync data changed off the change edge");
endmodule // usft_top

/* File: verification/usft_remote.sv */
/*
  usft_remote: remote asynchronous receiver that decodes the frames seen on
  the device's serial output, and the loop-back drive of the input pins.
  Assumes the bench sets bit time in pclk cycles and the frame format.
*/
module usft_remote (
  input wire logic pclk, // system clock
  input wire logic line, // serial line from the device
  input wire logic [7:0] bit_cyc, // clocks per bit
  input wire logic [3:0] nbits, // data bits per frame
  input wire logic par_en, // parity bit present
  input wire logic stop2, // two stop bits expected
  output logic [8:0] word, // last character
  output logic par, // last parity bit
  output logic stop_ok, // stop bits were high
  output logic [7:0] count, // frames decoded
  output logic rx_line, // line back to the device, a copy of line
  output logic xck // transfer clock, held low at all times
);
  timeunit 1ns;
  timeprecision 1ps;
  // toward the device: data echoed back (idles high with the line), stopped clock
  assign rx_line = line;
  assign xck = 1'b0;
  // sample mid-bit: start, data lsb first, parity, stop bits
  initial begin
    count = 8'h00;
    word = 9'h000;
    par = 1'b0;
    stop_ok = 1'b0;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge pclk);
      if (line === 1'b0) begin
        word = 9'h000;
        for (int i = 0; i < nbits; i++) begin
          repeat (bit_cyc) @(posedge pclk);
          word[i] = line;
        end
        if (par_en) begin
          repeat (bit_cyc) @(posedge pclk);
          par = line;
        end
        repeat (bit_cyc) @(posedge pclk);
        stop_ok = line;
        if (stop2) begin
          repeat (bit_cyc) @(posedge pclk);
          stop_ok = stop_ok & line;
        end
        count = count + 8'h01;
      end
    end
  end
endmodule // usft_remote

/* File: verification/testbench.sv */
/*
  testbench: drives the transmitter over APB and compares the frames decoded
  by the remote receiver model. Assumes the usft_pkg map and a 50 MHz pclk.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import usft_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, u2x;
  logic [7:0] paddr, p_bit, p_count, burst_c;
  logic [31:0] pwdata, prdata, v;
  logic sout, soe, sin, xin, xout, xoe, p_par_en, p_stop2, p_par, p_stop;
  logic [3:0] p_nb;
  logic [8:0] p_word;
  int err_total, samples_checked;
  localparam logic [2:0] SZ [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h3, 3'h0, 3'h7};
  localparam logic [1:0] PM [8] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
  localparam logic S2 [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [8:0] DT [8] = '{9'h1FF, 9'h0AA, 9'h155, 9'h0C3, 9'h1A5, 9'h07E, 9'h0F1, 9'h03C};

  usft_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_out_pin(sout), .serial_out_oe(soe), .serial_in_pin(sin), .xfer_clock_in(xin),
    .xfer_clock_out(xout), .xfer_clock_oe(xoe));
  usft_remote remote (.pclk(pclk), .line(soe ? sout : 1'b1), .bit_cyc(p_bit), .nbits(p_nb), .par_en(p_par_en),
    .stop2(p_stop2), .word(p_word), .par(p_par), .stop_ok(p_stop), .count(p_count),
    .rx_line(sin), .xck(xin));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access until pready at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_frame(input logic [7:0] c, input logic [8:0] m);
    int n;
    n = 0;
    while (p_count !== c && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    check(p_count, c);
    check(p_word, m);
    check(p_stop, 1);
  endtask

  task automatic wait_txc;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (v[1] !== 1'b1 && n < 500);
    check(v[1:0], 2'b11);
    check({soe, sout}, 2'b11);
  endtask

  // program a format, clear txc, send one character and check it
  task automatic frame(input logic [2:0] sz, input logic [1:0] pm, input logic s2, input logic [8:0] d);
    int nb;
    logic [8:0] m;
    logic [7:0] c;
    nb = (sz == 3'h7) ? 9 : ((sz < 3'h4) ? sz + 5 : 8);
    m = d & 9'((1 << nb) - 1);
    apb(1'b1, ADDR_CTRL_C, {23'h0, 1'b0, sz, s2, pm, 2'b00});
    p_nb <= 4'(nb);
    p_par_en <= pm[1];
    p_stop2 <= s2;
    apb(1'b1, ADDR_STATUS, {29'h0, u2x, 2'b10});
    apb(1'b1, ADDR_CTRL_B, {30'h0, d[8], 1'b1});
    c = p_count;
    apb(1'b1, ADDR_DATA, {24'hFFFFFF, d[7:0]});
    wait_frame(c + 8'h01, m);
    if (pm[1]) check(p_par, ^m ^ pm[0]);
    wait_txc;
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    u2x = 1'b0;
    p_bit = 8'h10;
    p_nb = 4'h8;
    p_par_en = 1'b0;
    p_stop2 = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check({soe, sout, xoe}, 3'b010);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(v[1:0], 2'b01);
    apb(1'b0, 8'h14, 32'h0);
    check(v, 32'h0);
    check(e, 1);
    apb(1'b1, ADDR_BAUD, 32'h0);
    apb(1'b1, ADDR_CTRL_B, 32'h1);
    @(posedge pclk);
    check({soe, sout}, 2'b11);
    for (int i = 0; i < 8; i++) frame(SZ[i], PM[i], S2[i], DT[i]);
    apb(1'b1, ADDR_CTRL_C, 32'h60);
    apb(1'b1, ADDR_STATUS, 32'h2);
    p_nb <= 4'h8;
    p_par_en <= 1'b0;
    p_stop2 <= 1'b0;
    burst_c = p_count;
    apb(1'b1, ADDR_DATA, 32'h5A);
    do apb(1'b0, ADDR_STATUS, 32'h0); while (v[0] !== 1'b1 && p_count === burst_c);
    apb(1'b1, ADDR_DATA, 32'hC3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(v[0], 0);
    wait_frame(burst_c + 8'h01, 9'h05A);
    wait_frame(burst_c + 8'h02, 9'h0C3);
    wait_txc;
    u2x = 1'b1;
    p_bit <= 8'h08;
    frame(3'h3, 2'h2, 1'b0, 9'h096);
    apb(1'b1, ADDR_CTRL_C, 32'h103);
    repeat (4) @(posedge pclk);
    check({xoe, xout}, 2'b11);
    apb(1'b1, ADDR_CTRL_C, 32'h1);
    @(posedge pclk);
    check(xoe, 0);
    // sync master frame, echoed by the peer into the receiver
    apb(1'b1, ADDR_STATUS, 32'h2);
    apb(1'b1, ADDR_BAUD, 32'h7);
    apb(1'b1, ADDR_CTRL_C, 32'h6B);
    p_bit <= 8'h10;
    p_nb <= 4'h8;
    p_par_en <= 1'b1;
    p_stop2 <= 1'b0;
    burst_c = p_count;
    apb(1'b1, ADDR_DATA, 32'h3C);
    wait_frame(burst_c + 8'h01, 9'h03C);
    check(p_par, 0);
    wait_txc;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(v[4:3], 2'b10);
    apb(1'b0, ADDR_DATA, 32'h0);
    check(v, 32'h03C);
    stop_test;
  end

  // watchdog against a hang
  initial begin
    #1000000;
    err_total++;
    stop_test;
  end
endmodule // testbench
